// ===== design/remap_lock_pkg.sv
// package: register map, field layout and constants of the remap lock guard
package remap_lock_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [11:0] OFF_OSC_CTRL   = 12'h000;
   localparam logic [11:0] OFF_CFG        = 12'h004;
   localparam logic [11:0] OFF_IRQ_STAT   = 12'h008;
   localparam logic [11:0] OFF_IRQ_EN     = 12'h00C;
   localparam logic [11:0] OFF_IRQ_CLR    = 12'h010;
   localparam logic [11:0] OFF_PIN_MASK   = 12'h014;
   localparam logic [11:0] OFF_IN_MAP     = 12'h100;
   localparam logic [11:0] OFF_OUT_MAP    = 12'h200;
   // ==========================================================
   // fields and keys
   localparam int          LOCK_BIT       = 6;
   localparam logic [7:0]  KEY_FIRST      = 8'h46;
   localparam logic [7:0]  KEY_SECOND     = 8'h57;
   localparam int          NUM_PINS       = 32;
   localparam int          NUM_IN_FUNCS   = 32;
   localparam int          NUM_OUT_FUNCS  = 32;
   localparam int          SEL_W          = 5;
   localparam logic [4:0]  SEL_NONE       = 5'h1F;
   localparam logic [4:0]  OUT_NONE       = 5'h00;
   localparam logic [31:0] PINS_28        = 32'hFC00EFFF;
   localparam logic [31:0] PINS_44        = 32'hFFFFEFFF;
   // interrupt status bits
   localparam int          EV_LOCK_CHG    = 0;
   localparam int          EV_DROPPED     = 1;
   localparam int          EV_MISMATCH    = 2;
   localparam int          EV_W           = 3;
   // ==========================================================
   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_OPEN} key_state_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// ===== design/remap_pin_lock_guard.sv
// remap pin lock guard: locked pin-to-function matrix with shadow check
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module remap_pin_lock_guard
   import remap_lock_pkg::*;
#(
   parameter bit PKG_44 = 1'b1
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     nrst,
   // apb slave
   input  wire apb_req_t                 apb_req,
   output apb_rsp_t                      apb_rsp,
   // configuration strap
   input  wire logic                     one_way_lock_cfg,
   // matrix
   input  wire logic [NUM_PINS-1:0]      pin_in,
   output logic [NUM_IN_FUNCS-1:0]       func_in,
   input  wire logic [NUM_OUT_FUNCS-1:0] func_out,
   input  wire logic [NUM_OUT_FUNCS-1:0] func_out_en,
   output logic [NUM_PINS-1:0]           pin_out,
   output logic [NUM_PINS-1:0]           pin_oe,
   // status
   output logic                          map_lock,
   output logic                          cfg_mismatch_rst,
   output logic                          irq
);
   // ==========================================================
   // storage
   logic [SEL_W-1:0]        in_map_ff  [NUM_IN_FUNCS];
   logic [SEL_W-1:0]        in_shd_ff  [NUM_IN_FUNCS];
   logic [SEL_W-1:0]        out_map_ff [NUM_PINS];
   logic [SEL_W-1:0]        out_shd_ff [NUM_PINS];
   logic                    lock_ff;
   logic                    lock_seen_ff;
   logic                    one_way_ff;
   logic                    mismatch_ff;
   key_state_t              key_ff;
   key_state_t              nxt_key;
   logic [EV_W-1:0]         stat_ff;
   logic [EV_W-1:0]         en_ff;
   logic [31:0]             rdata_ff;
   logic [31:0]             rd_sel;
   logic [NUM_IN_FUNCS-1:0] in_mis;
   logic [NUM_PINS-1:0]     out_mis;
   logic                    mis_now;
   // ==========================================================
   // bus decode
   wire             acc      = apb_req.psel & apb_req.penable;
   wire             setup    = apb_req.psel & ~apb_req.penable;
   wire             wr       = acc & apb_req.pwrite;
   wire [11:0]      a        = apb_req.paddr;
   wire [4:0]       idx      = a[6:2];
   wire [31:0]      wdata    = apb_req.pwdata;
   wire [SEL_W-1:0] wsel     = wdata[SEL_W-1:0];
   wire             hit_osc  = a == OFF_OSC_CTRL;
   wire             hit_cfg  = a == OFF_CFG;
   wire             hit_stat = a == OFF_IRQ_STAT;
   wire             hit_en   = a == OFF_IRQ_EN;
   wire             hit_clr  = a == OFF_IRQ_CLR;
   wire             hit_mask = a == OFF_PIN_MASK;
   wire             hit_in   = (a & 12'hF83) == OFF_IN_MAP;
   wire             hit_out  = (a & 12'hF83) == OFF_OUT_MAP;
   wire             mapped   = hit_osc | hit_cfg | hit_stat | hit_en |
                               hit_clr | hit_mask | hit_in | hit_out;
   wire [31:0]      pin_impl = PKG_44 ? PINS_44 : PINS_28;
   wire             idx_impl = pin_impl[idx];
   // ==========================================================
   // map write qualification
   wire             map_wr   = wr & (hit_in | hit_out);
   wire             map_ok   = map_wr & ~lock_ff;
   wire             map_drop = map_wr & lock_ff;
   wire             in_ld    = map_ok & hit_in;
   // absent pins keep their reset field, so they read back as zero
   wire             out_ld   = map_ok & hit_out & idx_impl;
   // ==========================================================
   // lock request decode
   wire             osc_wr   = wr & hit_osc;
   wire [7:0]       wbyte    = wdata[7:0];
   wire             key1_hit = wbyte == KEY_FIRST;
   wire             key2_hit = wbyte == KEY_SECOND;
   wire             key_open = key_ff == KEY_OPEN;
   wire             lock_req = wdata[LOCK_BIT];
   // clearing is refused in one-way mode once any set has been seen since reset
   wire             clr_ok   = ~(one_way_ff & lock_seen_ff);
   wire             lock_upd = osc_wr & key_open &
                               (lock_req | clr_ok);
   wire             lock_chg = lock_upd & (lock_req != lock_ff);
   wire             lock_set = lock_upd & lock_req;
   // ==========================================================
   // unlock key sequence
   always_comb begin
      nxt_key = key_ff;
      if (osc_wr) begin
         case (key_ff)
            KEY_IDLE: begin
               nxt_key = key1_hit ? KEY_GOT1 : KEY_IDLE;
            end
            KEY_GOT1: begin
               // a fresh first key restarts, anything else aborts
               if (key2_hit) begin
                  nxt_key = KEY_OPEN;
               end else if (key1_hit) begin
                  nxt_key = KEY_GOT1;
               end else begin
                  nxt_key = KEY_IDLE;
               end
            end
            KEY_OPEN: begin
               // the window admits one single lock write
               nxt_key = KEY_IDLE;
            end
            default: begin
               nxt_key = KEY_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         key_ff <= KEY_IDLE;
      end else begin
         key_ff <= nxt_key;
      end
   end
   // ==========================================================
   // lock bit and strap capture
   // no automatic relock: the bit only moves on a keyed write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lock_ff <= 1'b0;
      end else if (lock_upd) begin
         lock_ff <= lock_req;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lock_seen_ff <= 1'b0;
      end else if (lock_set) begin
         lock_seen_ff <= 1'b1;
      end
   end
   // restrictive setting until the strap is first sampled
   always_ff @(posedge clk) begin
      if (!nrst) begin
         one_way_ff <= 1'b1;
      end else begin
         one_way_ff <= one_way_lock_cfg;
      end
   end
   assign map_lock = lock_ff;
   // ==========================================================
   // map registers and their shadows; shadows load only on legal writes
   // so any other disturbance of the primary copy shows up as a mismatch
   for (genvar g = 0; g < NUM_IN_FUNCS; g++) begin : g_in_reg
      wire ld = in_ld && idx == SEL_W'(g);
      always_ff @(posedge clk) begin
         if (!nrst) begin
            in_map_ff[g] <= SEL_NONE;
            in_shd_ff[g] <= SEL_NONE;
         end else if (ld) begin
            in_map_ff[g] <= wsel;
            in_shd_ff[g] <= wsel;
         end
      end
   end
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_out_reg
      wire ld = out_ld && idx == SEL_W'(g);
      always_ff @(posedge clk) begin
         if (!nrst) begin
            out_map_ff[g] <= OUT_NONE;
            out_shd_ff[g] <= OUT_NONE;
         end else if (ld) begin
            out_map_ff[g] <= wsel;
            out_shd_ff[g] <= wsel;
         end
      end
   end
   // ==========================================================
   // continuous shadow comparison
   for (genvar g = 0; g < NUM_IN_FUNCS; g++) begin : g_in_cmp
      assign in_mis[g] = in_map_ff[g] != in_shd_ff[g];
   end
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_out_cmp
      assign out_mis[g] = out_map_ff[g] != out_shd_ff[g];
   end
   assign mis_now = |{in_mis, out_mis};
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mismatch_ff <= 1'b0;
      end else begin
         mismatch_ff <= mis_now;
      end
   end
   assign cfg_mismatch_rst = mismatch_ff;
   // ==========================================================
   // matrix: each sink has exactly one selector, so a sink can never have
   // two drivers; one source may feed many sinks
   for (genvar f = 0; f < NUM_IN_FUNCS; f++) begin : g_in_route
      wire [SEL_W-1:0] src = in_map_ff[f];
      // unimplemented pins read as idle zero
      assign func_in[f] = pin_impl[src] & pin_in[src];
   end
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_out_route
      wire [SEL_W-1:0] src  = out_map_ff[p];
      // output number 0 leaves the pin with its port logic
      wire             live = pin_impl[p] && src != OUT_NONE;
      wire             en   = live & func_out_en[src];
      assign pin_oe[p]  = en;
      assign pin_out[p] = en & func_out[src];
   end
   // ==========================================================
   // interrupt status
   wire             ev_lock  = lock_chg;
   wire             ev_drop  = map_drop;
   wire             ev_mis   = mis_now & ~mismatch_ff;
   wire [EV_W-1:0]  ev       = {ev_mis, ev_drop, ev_lock};
   wire             clr_wr   = wr & hit_clr;
   wire             en_wr    = wr & hit_en;
   wire [EV_W-1:0]  clr      = clr_wr ? wdata[EV_W-1:0] : '0;
   // set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~clr) | ev;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_ff <= '0;
      end else if (en_wr) begin
         en_ff <= wdata[EV_W-1:0];
      end
   end
   assign irq = |(stat_ff & en_ff);
   // ==========================================================
   // read data, registered during setup so access answers at once
   wire [31:0]      rd_osc   = 32'(lock_ff) << LOCK_BIT;
   wire [31:0]      rd_cfg   = {30'h0, lock_seen_ff, one_way_ff};
   wire [31:0]      rd_stat  = {{(32-EV_W){1'b0}}, stat_ff};
   wire [31:0]      rd_en    = {{(32-EV_W){1'b0}}, en_ff};
   wire [31:0]      rd_in    = {{(32-SEL_W){1'b0}}, in_map_ff[idx]};
   wire [31:0]      rd_out   = {{(32-SEL_W){1'b0}}, out_map_ff[idx]};
   always_comb begin
      rd_sel = 32'h0000_0000;
      case (a)
         OFF_OSC_CTRL: begin
            rd_sel = rd_osc;
         end
         OFF_CFG: begin
            rd_sel = rd_cfg;
         end
         OFF_IRQ_STAT: begin
            rd_sel = rd_stat;
         end
         OFF_IRQ_EN: begin
            rd_sel = rd_en;
         end
         OFF_PIN_MASK: begin
            rd_sel = pin_impl;
         end
         default: begin
            // map windows span many words, so they decode by mask
            if (hit_in) begin
               rd_sel = rd_in;
            end else if (hit_out) begin
               rd_sel = rd_out;
            end
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         rdata_ff <= rd_sel;
      end
   end
   // zero wait states: every access completes in its first cycle
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = acc & ~mapped;
   assign apb_rsp.prdata  = rdata_ff;
endmodule // remap_pin_lock_guard
`default_nettype wire

// ===== verif/remap_guard_checker.sv
// checker: port assertions for the remap pin lock guard
`timescale 1ns/1ps
`default_nettype none
module remap_guard_checker
   import remap_lock_pkg::*;
#(parameter bit PKG_44 = 1'b1) (
   // clock, reset and bus
   input wire logic        clk,
   input wire logic        nrst,
   input wire apb_req_t    apb_req,
   input wire apb_rsp_t    apb_rsp,
   // matrix and status
   input wire logic        one_way_lock_cfg,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] func_in,
   input wire logic [31:0] func_out,
   input wire logic [31:0] func_out_en,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic        map_lock,
   input wire logic        cfg_mismatch_rst,
   input wire logic        irq
);
   // =====
   // decode and properties
   wire logic        acc = apb_req.psel & apb_req.penable;
   wire logic        wr_osc = acc & apb_req.pwrite & (apb_req.paddr == 12'h000);
   wire logic        bit6 = apb_req.pwdata[LOCK_BIT];
   // 28-pin parts lack 12 and 16..25, 44-pin parts lack only 12
   wire logic [31:0] impl = PKG_44 ? 32'hFFFFEFFF : 32'hFC00EFFF;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_setup; apb_req.psel & !apb_req.penable; endsequence
   property p_ready; s_setup ##1 acc |-> apb_rsp.pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   // past reset masks the clearing edge of a mid-run reset
   property p_src; $past(nrst) && $changed(map_lock) |-> $past(wr_osc);
   endproperty
   a_src: assert property (p_src) else $error("lock moved");
   property p_set; $past(nrst) && $rose(map_lock) |-> $past(bit6); endproperty
   a_set: assert property (p_set) else $error("bad set");
   property p_clr; $past(nrst) && $fell(map_lock) |-> !$past(bit6); endproperty
   a_clr: assert property (p_clr) else $error("bad clear");
   property p_one;
      map_lock && one_way_lock_cfg && $past(one_way_lock_cfg) |=> map_lock;
   endproperty
   a_one: assert property (p_one) else $error("one-way");
   property p_impl; (pin_oe & ~impl) == 32'h0; endproperty
   a_impl: assert property (p_impl) else $error("unimpl pin");
   property p_hold;
      map_lock && $past(map_lock) && $stable(pin_in) && $stable(func_out)
      && $stable(func_out_en) |-> $stable(func_in) && $stable(pin_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("map moved");
   property p_mm; !cfg_mismatch_rst; endproperty
   a_mm: assert property (p_mm) else $error("mismatch");
endmodule // remap_guard_checker
bind remap_pin_lock_guard remap_guard_checker #(.PKG_44(PKG_44)) u_chk (.*);
`default_nettype wire

// ===== verif/testbench.sv
// testbench: directed bus scenarios for the remap pin lock guard
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import remap_lock_pkg::*;
   // =====
   // ports and bookkeeping
   localparam logic WR = 1'b1;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        one_way_lock_cfg = 1'b1;
   apb_req_t    apb_req = '0;
   apb_rsp_t    apb_rsp;
   logic [31:0] pin_in = '0;
   logic [31:0] func_out = '0;
   logic [31:0] func_out_en = '1;
   logic [31:0] func_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic        map_lock;
   logic        cfg_mismatch_rst;
   logic        irq;
   logic [31:0] rdq;
   logic        rse;
   logic [7:0]  ab [5] = '{8'h00, 8'h46, 8'h00, 8'h57, 8'h00};
   int          fails = 0;
   int          total_checks = 0;
   remap_pin_lock_guard #(.PKG_44(1'b1)) i_dut (.*);
   initial forever #10 clk = ~clk;
   // =====
   // bus and compare helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do @(posedge clk); while (apb_rsp.pready !== 1'b1);
      rdq = apb_rsp.prdata;
      rse = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdq, exp);
   endtask
   task automatic keys(input logic v);
      bus(WR, OFF_OSC_CTRL, 32'h46);
      bus(WR, OFF_OSC_CTRL, 32'h57);
      bus(WR, OFF_OSC_CTRL, {25'h0, v, 6'h0});
   endtask
   // =====
   // scenarios
   task automatic t_reset;
      chk({30'h0, map_lock, irq}, 32'h0);
      rdc(OFF_CFG, 32'h1);
      rdc(OFF_PIN_MASK, ~(32'h1 << 12));
      rdc(12'h0F0, 32'h0);
   endtask
   task automatic t_map;
      bus(WR, OFF_IN_MAP + 12'h00C, 32'h05);
      bus(WR, OFF_IN_MAP + 12'h010, 32'h05);
      bus(WR, OFF_OUT_MAP + 12'h01C, 32'h02);
      bus(WR, OFF_OUT_MAP + 12'h024, 32'h02);
      bus(WR, OFF_OUT_MAP + 12'h030, 32'h02);
      pin_in <= 32'h20;
      func_out <= 32'h4;
      @(negedge clk);
      chk({30'h0, func_in[4:3]}, 32'h3);
      chk(pin_out & pin_oe, 32'h280);
      chk(pin_oe, 32'h280);
      rdc(OFF_OUT_MAP + 12'h030, 32'h0);
   endtask
   task automatic t_lock;
      one_way_lock_cfg <= 1'b0;
      bus(WR, OFF_IRQ_EN, 32'h3);
      keys(1'b1);
      @(negedge clk);
      chk({30'h0, map_lock, irq}, 32'h3);
      bus(WR, OFF_IRQ_CLR, 32'h1);
      bus(WR, OFF_IN_MAP + 12'h00C, 32'h08);
      chk({31'h0, rse}, 32'h0);
      rdc(OFF_IN_MAP + 12'h00C, 32'h05);
      chk({30'h0, func_in[3], irq}, 32'h3);
      bus(WR, OFF_IRQ_EN, 32'h0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(WR, OFF_IRQ_CLR, 32'h7);
      for (int i = 0; i < 5; i++) bus(WR, OFF_OSC_CTRL, {24'h0, ab[i]});
      rdc(OFF_IRQ_STAT, 32'h0);
      keys(1'b0);
      bus(WR, OFF_IN_MAP + 12'h010, 32'h08);
      rdc(OFF_IN_MAP + 12'h010, 32'h08);
      chk({31'h0, map_lock}, 32'h0);
   endtask
   task automatic t_oneway;
      one_way_lock_cfg <= 1'b1;
      keys(1'b1);
      keys(1'b0);
      rdc(OFF_CFG, 32'h3);
      chk({31'h0, map_lock}, 32'h1);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdc(OFF_IN_MAP + 12'h00C, 32'h1F);
      chk({31'h0, map_lock}, 32'h0);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_map();
      t_lock();
      t_oneway();
      tally_and_finish();
   end
   // a hung bus wait ends here
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
